// File: design/smd_pkg.sv
// smd_pkg: constants and carrier types for the step/dir input logic
// assumes a single 100 MHz clock domain
package smd_pkg;
	localparam int unsigned CLK_HZ            = 100_000_000;
	localparam int unsigned MAX_PULSE_HZ      = 200_000;
	localparam int unsigned PULSE_MIN_CYC     = CLK_HZ / MAX_PULSE_HZ;
	localparam int unsigned IDLE_TIMEOUT_MS   = 100;
	localparam int unsigned IDLE_TIMEOUT_CYC  = (CLK_HZ / 1000) * IDLE_TIMEOUT_MS;
	localparam int unsigned POS_W             = 32;
	localparam int unsigned CUR_W             = 8;
	localparam logic [7:0] CUR_NOMINAL        = 8'h00_C0;
	localparam logic [7:0] CUR_BOOST          = 8'h00_F0;
	localparam logic [7:0] CUR_OFF            = 8'h00_00;
	// microstep increment in 1/256-step units
	localparam logic [8:0] INC_HALF           = 9'h0_080;
	localparam logic [8:0] INC_EIGHTH         = 9'h0_020;
	localparam logic [8:0] INC_256TH          = 9'h0_001;
	localparam logic [8:0] INC_RESET          = 9'h0_080;

	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_RUN   = 2'b01,
		ST_FAULT = 2'b10
	} smd_state_t;

	typedef struct packed {
		logic pulse;
		logic dir_ccw;
		logic enable;
		logic boost;
		logic res_sel;
	} smd_in_t;

	typedef struct packed {
		logic             stage_on;
		logic [CUR_W-1:0] current;
		logic             standstill;
		logic             fault;
	} smd_out_t;
endpackage

// File: design/smd_idle_timer.sv
// smd_idle_timer: counts cycles since the last step edge
// assumes step_evt is a one-cycle pulse in the ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module smd_idle_timer #(
	parameter int unsigned TIMEOUT = smd_pkg::IDLE_TIMEOUT_CYC
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic step_evt,
	output var  logic idle
);
	import smd_pkg::*;
	logic [31:0] cnt_reg;

	always_ff @(posedge ref_clk) begin
		if (reset || step_evt) begin
			cnt_reg <= 32'h0000_0000;
		end else if (cnt_reg < TIMEOUT) begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
		end
	end

	// starts idle after reset: a motor that never stepped is at standstill
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			idle <= 1'b1;
		end else if (step_evt) begin
			idle <= 1'b0;
		end else if (cnt_reg >= TIMEOUT - 1) begin
			idle <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: design/smd_step_ctrl.sv
// smd_step_ctrl: step/dir input logic of an integrated stepper driver
// assumes inputs already synchronous to ref_clk; fault flags come from analog monitors
`timescale 1ns/1ps
`default_nettype none
// Contract
// - each pulse rising edge moves position one microstep in chosen direction
// - direction low steps clockwise, high steps counter-clockwise
// - enable low turns motor current off, high turns it on
// - resolution latched only while enable low; set before raising enable
// - standard variant: low half step, high eighth step
// - low-noise variant: low eighth step, high 1/256 step
// - torque-raise high increases drive current
// - at standstill phase current drops to two thirds of the nominal or boost level
// - over-temperature or supply fault switches stage off and holds it
// - restart only on fresh enable rising edge after fault clears
module smd_step_ctrl #(
	parameter int unsigned IDLE_CYC  = smd_pkg::IDLE_TIMEOUT_CYC,
	parameter bit          LOW_NOISE = 1'b0
) (
	input  wire logic                     ref_clk,
	input  wire logic                     reset,
	input  wire smd_pkg::smd_in_t         ctl_in,
	input  wire logic                     over_temp,
	input  wire logic                     supply_bad,
	output var  smd_pkg::smd_out_t        drv_out,
	output var  logic [smd_pkg::POS_W-1:0] position
);
	import smd_pkg::*;

	smd_state_t state_reg;
	smd_state_t state_next;
	logic       pulse_q_reg;
	logic       enable_q_reg;
	logic       res_reg;
	logic       idle;
	logic       step_evt;
	logic       enable_rise;
	logic       fault_now;
	logic [8:0] inc;
	logic [CUR_W-1:0] cur_base;
	logic [CUR_W-1:0] cur_next;

	assign step_evt    = ctl_in.pulse && !pulse_q_reg;
	assign enable_rise = ctl_in.enable && !enable_q_reg;
	assign fault_now   = over_temp || supply_bad;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pulse_q_reg  <= 1'b0;
			enable_q_reg <= 1'b0;
		end else begin
			pulse_q_reg  <= ctl_in.pulse;
			enable_q_reg <= ctl_in.enable;
		end
	end

	// resolution follows the pin only while disabled
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			res_reg <= 1'b0;
		end else if (!ctl_in.enable) begin
			res_reg <= ctl_in.res_sel;
		end
	end

	always_comb begin
		if (LOW_NOISE) begin
			inc = res_reg ? INC_256TH : INC_EIGHTH;
		end else begin
			inc = res_reg ? INC_EIGHTH : INC_HALF;
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_OFF: begin
				if (fault_now) begin
					state_next = ST_FAULT;
				end else if (ctl_in.enable) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (fault_now) begin
					state_next = ST_FAULT;
				end else if (!ctl_in.enable) begin
					state_next = ST_OFF;
				end
			end
			ST_FAULT: begin
				// a level already high does not re-arm; needs a new edge
				if (!fault_now && enable_rise) begin
					state_next = ST_RUN;
				end
			end
			default: state_next = ST_FAULT;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	smd_idle_timer #(
		.TIMEOUT (IDLE_CYC)
	) u_idle (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.step_evt (step_evt),
		.idle     (idle)
	);

	// every edge in ST_RUN is counted: one cycle per edge suffices far above 200 kHz
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			position <= '0;
		end else if (step_evt && state_reg == ST_RUN) begin
			if (ctl_in.dir_ccw) begin
				position <= position - POS_W'(inc);
			end else begin
				position <= position + POS_W'(inc);
			end
		end
	end

	always_comb begin
		cur_base = ctl_in.boost ? CUR_BOOST : CUR_NOMINAL;
		if (state_next != ST_RUN) begin
			cur_next = CUR_OFF;
		end else if (idle && !step_evt) begin
			cur_next = CUR_W'((16'(cur_base) * 16'd2) / 16'd3);
		end else begin
			cur_next = cur_base;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			drv_out <= '0;
		end else begin
			drv_out.stage_on   <= (state_next == ST_RUN);
			drv_out.current    <= cur_next;
			drv_out.standstill <= idle && !step_evt;
			drv_out.fault      <= (state_next == ST_FAULT);
		end
	end

	AST_FAULT_OFF: assert property (@(posedge ref_clk) disable iff (reset)
		fault_now |=> !drv_out.stage_on && drv_out.current == CUR_OFF)
		else $error("stage not off after fault");

	AST_FAULT_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == ST_FAULT && !enable_rise |=> state_reg == ST_FAULT)
		else $error("left fault without enable edge");

	AST_REARM: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == ST_FAULT && enable_rise && !fault_now |=> drv_out.stage_on)
		else $error("no restart on enable edge");

	AST_DISABLE: assert property (@(posedge ref_clk) disable iff (reset)
		!ctl_in.enable |=> !drv_out.stage_on)
		else $error("stage on while disabled");

	AST_STEP_CW: assert property (@(posedge ref_clk) disable iff (reset)
		step_evt && state_reg == ST_RUN && !ctl_in.dir_ccw
		|=> position == $past(position) + POS_W'($past(inc)))
		else $error("cw step wrong");

	AST_STEP_CCW: assert property (@(posedge ref_clk) disable iff (reset)
		step_evt && state_reg == ST_RUN && ctl_in.dir_ccw
		|=> position == $past(position) - POS_W'($past(inc)))
		else $error("ccw step wrong");

	AST_RES_LOCK: assert property (@(posedge ref_clk) disable iff (reset)
		ctl_in.enable && $past(ctl_in.enable) |-> $stable(res_reg))
		else $error("resolution changed while enabled");

	// step sizes are checked on the position itself, not on the increment mux
	AST_RES_STD: assert property (@(posedge ref_clk) disable iff (reset)
		!LOW_NOISE && step_evt && state_reg == ST_RUN && !ctl_in.dir_ccw
		|=> position - $past(position) == POS_W'($past(res_reg) ? 32 : 128))
		else $error("standard step size wrong");

	AST_RES_LN: assert property (@(posedge ref_clk) disable iff (reset)
		LOW_NOISE && step_evt && state_reg == ST_RUN && !ctl_in.dir_ccw
		|=> position - $past(position) == POS_W'($past(res_reg) ? 1 : 32))
		else $error("low-noise step size wrong");

	AST_IDLE_CUR: assert property (@(posedge ref_clk) disable iff (reset)
		drv_out.stage_on && drv_out.standstill |->
		drv_out.current == CUR_NOMINAL * 2 / 3 || drv_out.current == CUR_BOOST * 2 / 3)
		else $error("standstill current not reduced");

	AST_EDGE_FULL: assert property (@(posedge ref_clk) disable iff (reset)
		step_evt && state_next == ST_RUN |=> !drv_out.standstill
		&& drv_out.current == ($past(ctl_in.boost) ? CUR_BOOST : CUR_NOMINAL))
		else $error("full current not restored");

	// fault handling: the flag and the off state must appear together
	AST_FAULT_FLAG: assert property (@(posedge ref_clk) disable iff (reset)
		fault_now
		|=> drv_out.fault)
		else $error("fault flag missing");

	AST_FAULT_STATE: assert property (@(posedge ref_clk) disable iff (reset)
		fault_now
		|=> state_reg == ST_FAULT)
		else $error("fault state not entered");

	AST_FAULT_EXCL: assert property (@(posedge ref_clk) disable iff (reset)
		drv_out.fault
		|-> !drv_out.stage_on)
		else $error("stage on while fault shown");

	AST_ENABLE_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == ST_FAULT && !fault_now && !enable_rise
		|=> !drv_out.stage_on)
		else $error("restart without enable edge");

	// power state follows the enable level outside faults
	AST_ENABLE_ON: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == ST_OFF && ctl_in.enable && !fault_now
		|=> drv_out.stage_on)
		else $error("stage not on after enable");

	AST_RUN_ON: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == ST_RUN && ctl_in.enable && !fault_now
		|=> drv_out.stage_on && !drv_out.fault)
		else $error("stage dropped while running");

	AST_OFF_CUR: assert property (@(posedge ref_clk) disable iff (reset)
		!drv_out.stage_on
		|-> drv_out.current == CUR_OFF)
		else $error("current while stage off");

	AST_OFF_NO_FAULT: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == ST_OFF && !fault_now && !ctl_in.enable
		|=> !drv_out.fault)
		else $error("fault shown while simply off");

	AST_NO_STEP_OFF: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg != ST_RUN
		|=> position == $past(position))
		else $error("position moved while not running");

	AST_NO_EDGE_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		!step_evt
		|=> $stable(position))
		else $error("position moved without edge");

	AST_RES_OPEN: assert property (@(posedge ref_clk) disable iff (reset)
		!ctl_in.enable
		|=> res_reg == $past(ctl_in.res_sel))
		else $error("resolution not taken while disabled");

	// current level checks; boost raises the current both while moving and at standstill
	AST_BOOST_CUR: assert property (@(posedge ref_clk) disable iff (reset)
		state_next == ST_RUN && ctl_in.boost && !idle
		|=> drv_out.current == CUR_BOOST)
		else $error("boost current wrong");

	AST_NOMINAL_CUR: assert property (@(posedge ref_clk) disable iff (reset)
		state_next == ST_RUN && !ctl_in.boost && !idle
		|=> drv_out.current == CUR_NOMINAL)
		else $error("nominal current wrong");

	AST_REDUCED_NOM: assert property (@(posedge ref_clk) disable iff (reset)
		drv_out.stage_on && drv_out.standstill && !$past(ctl_in.boost)
		|-> drv_out.current == CUR_W'((CUR_NOMINAL * 2) / 3))
		else $error("reduced nominal current wrong");

	AST_REDUCED_BOOST: assert property (@(posedge ref_clk) disable iff (reset)
		drv_out.stage_on && drv_out.standstill && $past(ctl_in.boost)
		|-> drv_out.current == CUR_W'((CUR_BOOST * 2) / 3))
		else $error("reduced boost current wrong");

	// standstill detection and its release on a new edge
	AST_STILL_FLAG: assert property (@(posedge ref_clk) disable iff (reset)
		idle && !step_evt
		|=> drv_out.standstill)
		else $error("standstill not flagged");

	AST_STILL_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
		step_evt
		|=> !drv_out.standstill)
		else $error("standstill kept after edge");

	AST_IDLE_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
		step_evt
		|=> !idle)
		else $error("idle timer not restarted");
endmodule
`default_nettype wire

// File: tb/smd_ctl_model.sv
// smd_ctl_model: motion controller model issuing microstep pulses
// assumes ref_clk at 100 MHz; pulse changes 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module smd_ctl_model (
	input  wire logic ref_clk,
	output var  logic pulse
);
	import smd_pkg::*;
	// runs at the fastest legal rate so the limit itself gets exercised
	localparam int HALF = PULSE_MIN_CYC / 2;
	initial pulse = 1'b0;
	task automatic send(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1 pulse = 1'b1;
			repeat (HALF) @(posedge ref_clk);
			#1 pulse = 1'b0;
			repeat (HALF - 1) @(posedge ref_clk);
		end
	endtask
endmodule
`default_nettype wire

// File: tb/smd_step_ctrl_tb.sv
// smd_step_ctrl_tb: directed test of both resolution variants side by side
// assumes smd_pkg and smd_ctl_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module smd_step_ctrl_tb;
	import smd_pkg::*;
	logic             ref_clk = 1'b0;
	logic             reset, dir_ccw, enable, boost, res_sel, over_temp, supply_bad, pulse, res_lat;
	smd_in_t          ctl_in;
	smd_out_t         out_s, out_l;
	logic [POS_W-1:0] pos_s, pos_l;
	int               errors, comparisons, exp_s, exp_l;
	assign ctl_in = {pulse, dir_ccw, enable, boost, res_sel};
	always #5 ref_clk = ~ref_clk;
	smd_ctl_model smd_ctl_model_inst (.ref_clk(ref_clk), .pulse(pulse));
	smd_step_ctrl #(.IDLE_CYC(50), .LOW_NOISE(1'b0)) smd_step_ctrl_inst (.ref_clk(ref_clk), .reset(reset),
		.ctl_in(ctl_in), .over_temp(over_temp), .supply_bad(supply_bad), .drv_out(out_s), .position(pos_s));
	smd_step_ctrl #(.IDLE_CYC(50), .LOW_NOISE(1'b1)) smd_step_ctrl_inst_ln (.ref_clk(ref_clk), .reset(reset),
		.ctl_in(ctl_in), .over_temp(over_temp), .supply_bad(supply_bad), .drv_out(out_l), .position(pos_l));
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic fail(input string m);
		errors++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask
	task automatic chk_out(input logic on, input logic [7:0] cur, input logic flt);
		comparisons++;
		if ({out_s.stage_on, out_s.current, out_s.fault} !== {on, cur, flt} || out_l !== out_s)
			fail("drive output");
	endtask
	task automatic chk_on(input logic on);
		comparisons++;
		if (out_s.stage_on !== on || out_l.stage_on !== on)
			fail("stage state");
	endtask
	task automatic chk_still(input logic s);
		comparisons++;
		if (out_s.standstill !== s || out_l.standstill !== s)
			fail("standstill");
	endtask
	task automatic chk_pos();
		comparisons++;
		if (pos_s !== POS_W'(exp_s) || pos_l !== POS_W'(exp_l))
			fail("position");
	endtask
	// moves says whether the driver is expected to follow the pulses
	task automatic step(input int n, input bit moves);
		int d;
		d = dir_ccw ? -n : n;
		smd_ctl_model_inst.send(n);
		#1;
		if (moves) begin
			exp_s += d * (res_lat ? 32 : 128);
			exp_l += d * (res_lat ? 1 : 32);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#1_000_000;
		fail("run timeout");
		give_verdict();
	end
	initial begin
		reset = 1'b1;
		{dir_ccw, enable, boost, res_sel, over_temp, supply_bad, res_lat} = '0;
		errors = 0;
		comparisons = 0;
		exp_s = 0;
		exp_l = 0;
		tick(12);
		reset = 1'b0;
		tick(1);
		chk_out(1'b0, 8'h00, 1'b0);
		chk_pos();
		enable = 1'b1;
		tick(3);
		chk_out(1'b1, 8'h80, 1'b0);
		chk_still(1'b1);
		step(3, 1'b1);
		chk_pos();
		chk_out(1'b1, 8'h80, 1'b0);
		fork
			step(1, 1'b1);
			begin
				tick(5);
				chk_out(1'b1, 8'hC0, 1'b0);
				chk_still(1'b0);
			end
		join
		boost = 1'b1;
		tick(3);
		chk_out(1'b1, 8'hA0, 1'b0);
		chk_still(1'b1);
		fork
			step(1, 1'b1);
			begin
				tick(5);
				chk_out(1'b1, 8'hF0, 1'b0);
			end
		join
		boost = 1'b0;
		$display("test stepping done");
		dir_ccw = 1'b1;
		step(2, 1'b1);
		chk_pos();
		// resolution must not follow the select input while powered
		res_sel = 1'b1;
		step(1, 1'b1);
		chk_pos();
		enable = 1'b0;
		tick(3);
		chk_out(1'b0, 8'h00, 1'b0);
		step(1, 1'b0);
		chk_pos();
		enable = 1'b1;
		res_lat = 1'b1;
		tick(3);
		step(2, 1'b1);
		chk_pos();
		$display("test resolution done");
		for (int k = 0; k < 2; k++) begin
			{over_temp, supply_bad} = k ? 2'b01 : 2'b10;
			tick(3);
			chk_out(1'b0, 8'h00, 1'b1);
			step(1, 1'b0);
			chk_pos();
			{over_temp, supply_bad} = 2'b00;
			tick(3);
			chk_on(1'b0);
			enable = 1'b0;
			tick(3);
			enable = 1'b1;
			tick(3);
			chk_out(1'b1, 8'h80, 1'b0);
		end
		$display("test faults done");
		give_verdict();
	end
endmodule
`default_nettype wire
